// ### rtl/pcae_defs.svh
/*
 * Constants for the pack configuration and alert enable register bank:
 * register offsets, reset values, writable masks, field positions,
 * selection encodings and timing figures.
 * Assumes it is included by its bare name and holds definitions only.
 */
`ifndef PCAE_DEFS_SVH
`define PCAE_DEFS_SVH

// Register offsets on the plain register port.
`define PCAE_ADDR_PACK_CFG    8'h18
`define PCAE_ADDR_ALERT_EN    8'h19
`define PCAE_ADDR_STATUS      8'h1a
`define PCAE_ADDR_ROUTE       8'h1b

// Reset values; reserved bits reset to zero.
`define PCAE_PACK_CFG_RST     16'hefff
`define PCAE_ALERT_EN_RST     16'h3fbf

// Writable bits; reserved bits stay zero and read back as zero.
`define PCAE_PACK_CFG_WMASK   16'hefff
`define PCAE_ALERT_EN_WMASK   16'hbfbf

// Alert bit positions that are kept out of some notifications.
`define PCAE_SCAN_ALERT_BIT   15
`define PCAE_PEC_ALERT_BIT    5

// Which alerts may reach each destination.
`define PCAE_PIN_INCL         16'hffff
`define PCAE_PACKET_INCL      16'h7fff
`define PCAE_LINK_INCL        16'h7fdf

// Cell and block selection encodings.
`define PCAE_SEL_OFF          4'hf
`define PCAE_SEL_MIN          4'h8
`define PCAE_SEL_MAX          4'he

// Timing: clock rate in MHz and the top-cell settling delay in us.
`define PCAE_CLK_MHZ          250
`define PCAE_SCAN_DELAY_US    30

`endif

// ### rtl/pcae_pkg.sv
/*
 * Types shared by the pack configuration register bank: the layout of
 * the pack configuration word, the decoded routing word and scan states.
 * Assumes the constants header is compiled alongside it.
 */
package pcae_pkg;

    // Stored pack configuration word, most significant field first.
    typedef struct packed {
        logic       flexB;     // Flexible-pack enable, primary copy.
        logic       flexA;     // Flexible-pack enable, redundant copy.
        logic       scanOpt;   // Settling delay before top-cell sampling.
        logic       rsvd;      // Reserved, always zero.
        logic [3:0] blockTap;  // Block divider tap selection.
        logic [3:0] cellB;     // Top-cell selection, primary copy.
        logic [3:0] cellA;     // Top-cell selection, redundant copy.
    } pcae_pack_cfg_s;

    // Decoded routing, sixteen bits so it reads back as one word.
    typedef struct packed {
        logic       flexEff;       // Effective flexible-pack enable.
        logic       cellSupported; // Copies agree and lie in 0x8..0xE.
        logic       supplyOn;      // Supply-input switch is closed.
        logic [3:0] supplySel;     // Switch input on the supply pin.
        logic [3:0] blockTap;      // Divider tap, 0xF is the block pin.
        logic       balMaskOn;     // Balance-switch alert masking active.
        logic [3:0] balMaskTop;    // Top cell used for that masking.
    } pcae_route_s;

    // Top-cell sampling sequencer states.
    typedef enum logic [0:0] {
        SCAN_IDLE = 1'b0,
        SCAN_WAIT = 1'b1
    } pcae_scan_e;

endpackage : pcae_pkg

// ### rtl/pcae_flex_decode.sv
/*
 * Combinational decode of the stored pack configuration into the
 * effective enable, supply-input switch routing, block divider tap and
 * balance-switch alert masking.
 * Assumes its caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcae_defs.svh"

module pcae_flex_decode (
    input  wire pcae_pkg::pcae_pack_cfg_s cfg,
    output pcae_pkg::pcae_route_s         route
);

    logic flexAgree;    // Both enable copies hold the same value.
    logic cellAgree;    // Both top-cell copies hold the same value.
    logic cellInRange;  // Top cell lies in the supported span.
    logic blockInRange; // Block tap lies in the supported span.

    assign flexAgree    = (cfg.flexA == cfg.flexB);
    assign cellAgree    = (cfg.cellA == cfg.cellB);
    assign cellInRange  = (cfg.cellA >= `PCAE_SEL_MIN) && (cfg.cellA <= `PCAE_SEL_MAX);
    assign blockInRange = (cfg.blockTap >= `PCAE_SEL_MIN) && (cfg.blockTap <= `PCAE_SEL_MAX);

    // A disagreeing enable pair reads as enabled but opens the switch.
    always_comb begin
        route               = '0;
        route.flexEff       = flexAgree ? cfg.flexA : 1'b1; // R2 R1
        route.cellSupported = cellAgree & cellInRange; // R8
        route.supplyOn      = route.flexEff & flexAgree & route.cellSupported; // R11 R12 R9
        route.supplySel     = route.supplyOn ? cfg.cellA : `PCAE_SEL_OFF; // R10 R12
        if (route.flexEff && blockInRange) begin
            route.blockTap = cfg.blockTap; // R5
        end else begin
            route.blockTap = `PCAE_SEL_OFF; // R6 R7
        end
        // Masking ignores the enable; every agreed value except 0xF masks.
        route.balMaskOn  = cellAgree & (cfg.cellA != `PCAE_SEL_OFF); // R9 R10 R13
        route.balMaskTop = route.balMaskOn ? cfg.cellA : `PCAE_SEL_OFF; // R13
    end

endmodule : pcae_flex_decode
`default_nettype wire

// ### rtl/pcae_alert_mask.sv
/*
 * Gates each summary status bit by its enable and by a fixed inclusion
 * mask for one destination, and ORs the result into one request.
 * Assumes status and enables come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module pcae_alert_mask #(
    parameter int         W    = 16,
    parameter logic [W-1:0] INCL = '1
) (
    input  wire logic [W-1:0] status,
    input  wire logic [W-1:0] enable,
    output logic              any
);

    logic [W-1:0] masked; // Status bits that pass this destination.

    // One AND per included alert source; excluded sources are tied to zero.
    for (genvar i = 0; i < W; i++) begin : g_bit
        if (INCL[i]) begin : g_on
            assign masked[i] = status[i] & enable[i];
        end else begin : g_off
            assign masked[i] = 1'b0;
        end
    end

    // Any passing source raises the request.
    assign any = |masked;

endmodule : pcae_alert_mask
`default_nettype wire

// ### rtl/pcae_regs.sv
/*
 * Pack configuration and alert enable register bank. Holds the flexible-
 * pack setup, decodes it into supply-switch and divider routing and
 * balance-switch masking, times the top-cell settling delay, and gates
 * summary alerts onto the alert pin, link status byte and alert packet.
 * Assumes a register master on the same clock, a sequencer that asks for
 * top-cell sampling on the same clock, and a summary status vector from
 * logic on the same clock.
 */
// The plain strobed port was chosen for this implementation.
// Summary of operation
// (R1) Enable copy at bit 14, reset enabled.
// (R2) Disagreeing enables: enabled, supply switch off.
// (R3) Scan option adds 30us before top-cell sampling.
// (R4) Delay only with flex, valid cell, altmux.
// (R5) Bits 11:8 pick divider tap, 0xF pin.
// (R6) Block values 0x0-0x7 act as 0xF.
// (R7) Flex disabled keeps the dedicated block pin.
// (R8) Top-cell copies valid only when equal.
// (R9) Disagreeing cells: no masking, switch off.
// (R10) Top cell 0xF: no masking, switch off.
// (R11) Cells 0x8-0xE connect switch inputs 8-14.
// (R12) Cells 0x0-0x7 and 0xF switch off.
// (R13) Top cell always sets balance-switch masking.
// (R14) Each enable bit gates its alert.
// (R15) Status reads stay unmasked.
// (R16) Scan alert reaches pins only, resets 0.
// (R17) Packet-check alert skips the link byte.
// (R18) Alert is OR of status AND enable.
// (R19) Routing follows a write on next cycle.
`timescale 1ns/10ps
`default_nettype none
`include "pcae_defs.svh"

module pcae_regs #(
    // Settling delay in cycles; shorten in simulation.
    parameter int SCAN_DELAY_CYC = `PCAE_SCAN_DELAY_US * `PCAE_CLK_MHZ,
    // Register port address width.
    parameter int ADDR_W         = 8
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [ADDR_W-1:0]     regAddr,
    input  wire logic [15:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [15:0]           regRdata_r,
    input  wire logic [15:0]           summaryStatus,
    input  wire logic                  topSampleReq,
    input  wire logic                  altMuxSelEff,
    output logic                       topSampleGo_r,
    output logic                       scanBusy_r,
    output pcae_pkg::pcae_route_s      route_r,
    output logic                       alertPin_r,
    output logic                       linkByteAlert_r,
    output logic                       packetAlert_r
);

    // Width of the settling counter, sized from the delay.
    localparam int CNT_W = $clog2(SCAN_DELAY_CYC + 1);

    pcae_pkg::pcae_pack_cfg_s pack_config_r;   // Stored pack configuration.
    logic [15:0]              alertEn_r;   // Stored alert enables.
    pcae_pkg::pcae_route_s    routeNxt;    // Decoded routing.
    pcae_pkg::pcae_scan_e     scanState_r; // Sequencer state.
    logic [CNT_W-1:0]         scanCnt_r;   // Remaining settle cycles.
    logic                     delayApplies; // Settling delay is due.
    logic                     pinAny;      // Pin request, unregistered.
    logic                     linkAny;     // Link byte request.
    logic                     packetAny;   // Alert packet request.
    logic [15:0]              rdataNxt;    // Read data before the flop.

    // Address decode for the two documented registers.
    logic hitPack;
    logic hitAlert;
    assign hitPack  = (regAddr == ADDR_W'(`PCAE_ADDR_PACK_CFG));
    assign hitAlert = (regAddr == ADDR_W'(`PCAE_ADDR_ALERT_EN));

    // Pack configuration storage; reserved bit 12 cannot be set.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pack_config_r <= `PCAE_PACK_CFG_RST; // R1 R5 R10
        end else if (regWr && hitPack) begin
            pack_config_r <= regWdata & `PCAE_PACK_CFG_WMASK; // R1
        end
    end

    // Alert enable storage; reserved bits 14 and 6 stay zero.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            alertEn_r <= `PCAE_ALERT_EN_RST; // R16
        end else if (regWr && hitAlert) begin
            alertEn_r <= regWdata & `PCAE_ALERT_EN_WMASK; // R14 R18
        end
    end

    // Routing decode; kept in its own module so it can be reused by the
    // sequencer side without a second copy of the redundancy checks.
    pcae_flex_decode u_decode (
        .cfg   (pack_config_r),
        .route (routeNxt)
    );

    // Routing is registered so the analog switch controls never glitch;
    // the cost is one cycle between a write and the new routing.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            route_r <= '0;
        end else begin
            route_r <= routeNxt; // R19
        end
    end

    // The delay needs a supported top cell, flex enabled and altmux on.
    assign delayApplies = pack_config_r.scanOpt & route_r.flexEff &
                          route_r.cellSupported & altMuxSelEff; // R4

    // Top-cell sampling sequencer: requests during a wait are dropped,
    // since the sequencer only issues one per scan.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scanState_r <= pcae_pkg::SCAN_IDLE;
            scanCnt_r   <= '0;
        end else begin
            case (scanState_r)
                pcae_pkg::SCAN_IDLE: begin
                    // A due delay starts the settle count.
                    if (topSampleReq && delayApplies) begin
                        scanState_r <= pcae_pkg::SCAN_WAIT; // R3
                        scanCnt_r   <= CNT_W'(SCAN_DELAY_CYC - 1);
                    end
                end
                pcae_pkg::SCAN_WAIT: begin
                    // Count down and return once the delay is spent.
                    if (scanCnt_r == '0) begin
                        scanState_r <= pcae_pkg::SCAN_IDLE; // R3
                    end else begin
                        scanCnt_r <= scanCnt_r - 1'b1;
                    end
                end
                default: begin
                    // Recover from an impossible code.
                    scanState_r <= pcae_pkg::SCAN_IDLE;
                end
            endcase
        end
    end

    // Sampling permission is a one-cycle pulse.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            topSampleGo_r <= 1'b0;
        end else if (scanState_r == pcae_pkg::SCAN_IDLE) begin
            // Without a due delay the sample goes at once.
            topSampleGo_r <= topSampleReq & ~delayApplies; // R3 R4
        end else begin
            topSampleGo_r <= (scanCnt_r == '0); // R3
        end
    end

    // Busy flag mirrors the wait state.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scanBusy_r <= 1'b0;
        end else begin
            scanBusy_r <= (scanState_r == pcae_pkg::SCAN_IDLE) ?
                          (topSampleReq & delayApplies) :
                          (scanCnt_r != '0);
        end
    end

    // Alert pins see every enabled alert.
    pcae_alert_mask #(
        .W    (16),
        .INCL (`PCAE_PIN_INCL)
    ) u_pin_mask (
        .status (summaryStatus),
        .enable (alertEn_r),
        .any    (pinAny)
    );

    // The link status byte leaves out scan done and packet check.
    pcae_alert_mask #(
        .W    (16),
        .INCL (`PCAE_LINK_INCL)
    ) u_link_mask (
        .status (summaryStatus),
        .enable (alertEn_r),
        .any    (linkAny)
    );

    // The alert packet leaves out only scan done.
    pcae_alert_mask #(
        .W    (16),
        .INCL (`PCAE_PACKET_INCL)
    ) u_packet_mask (
        .status (summaryStatus),
        .enable (alertEn_r),
        .any    (packetAny)
    );

    // Alert requests are registered so each output is a clean level.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            alertPin_r      <= 1'b0;
            linkByteAlert_r <= 1'b0;
            packetAlert_r   <= 1'b0;
        end else begin
            alertPin_r      <= pinAny; // R14 R18
            linkByteAlert_r <= linkAny; // R16 R17
            packetAlert_r   <= packetAny; // R16 R17
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        rdataNxt = 16'h0000;
        if (regAddr == ADDR_W'(`PCAE_ADDR_PACK_CFG)) begin
            rdataNxt = pack_config_r;
        end else if (regAddr == ADDR_W'(`PCAE_ADDR_ALERT_EN)) begin
            rdataNxt = alertEn_r; // R18
        end else if (regAddr == ADDR_W'(`PCAE_ADDR_STATUS)) begin
            // Status is read raw, never through the enables.
            rdataNxt = summaryStatus; // R15
        end else if (regAddr == ADDR_W'(`PCAE_ADDR_ROUTE)) begin
            rdataNxt = route_r;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdata_r <= 16'h0000;
        end else if (regRd) begin
            regRdata_r <= rdataNxt;
        end else begin
            regRdata_r <= 16'h0000;
        end
    end

    // Helper count of cycles spent waiting, read only by assertions.
    logic [31:0] waitCnt_r;
    always_ff @(posedge clk) begin
        if (!rstn || scanState_r == pcae_pkg::SCAN_IDLE) begin
            waitCnt_r <= 32'h0000_0000;
        end else begin
            waitCnt_r <= waitCnt_r + 32'h0000_0001;
        end
    end

    // Assertions share the one clock and its reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Reserved enable bits always read back as zero.
    rsvd_read_zero_a : assert property ( // R18
        regRd && hitAlert |=> regRdata_r[14] == 1'b0 && regRdata_r[6] == 1'b0
    ) else $error("Reserved alert enable bit read as one.");

    // Pin request is the OR of enabled status bits, one cycle later.
    pin_or_a : assert property ( // R14
        ##1 alertPin_r == |($past(summaryStatus) & $past(alertEn_r))
    ) else $error("Alert pin does not follow enabled status.");

    // A lone scan alert never reaches the link byte or the packet.
    scan_pins_only_a : assert property ( // R16
        (summaryStatus & 16'h7fff) == 16'h0000 |=> !linkByteAlert_r && !packetAlert_r
    ) else $error("Scan alert leaked into link notifications.");

    // Packet check reaches the packet but never the link byte.
    pec_no_link_a : assert property ( // R17
        summaryStatus == 16'h0020 && alertEn_r[5]
        |=> !linkByteAlert_r && packetAlert_r
    ) else $error("Packet check alert routed wrongly.");

    // Status readback returns the raw vector.
    status_raw_a : assert property ( // R15
        regRd && regAddr == ADDR_W'(`PCAE_ADDR_STATUS)
        |=> regRdata_r == $past(summaryStatus)
    ) else $error("Status readback was masked.");

    // Disagreeing enable copies read as enabled, switch open.
    flex_disagree_a : assert property ( // R2
        pack_config_r.flexA != pack_config_r.flexB |=> route_r.flexEff && !route_r.supplyOn
    ) else $error("Enable disagreement not handled.");

    // Disagreeing top-cell copies mask nothing and open the switch.
    cell_disagree_a : assert property ( // R9
        pack_config_r.cellA != pack_config_r.cellB
        |=> !route_r.balMaskOn && !route_r.supplyOn
    ) else $error("Top-cell disagreement not handled.");

    // Low block values and a disabled flex keep the block pin.
    block_pin_a : assert property ( // R6
        pack_config_r.blockTap < 4'h8 || (pack_config_r.flexA == pack_config_r.flexB && !pack_config_r.flexA)
        |=> route_r.blockTap == 4'hf
    ) else $error("Block tap left the dedicated pin.");

    // A supported block value with flex on reaches the divider tap.
    block_tap_a : assert property ( // R5
        pack_config_r.flexA && pack_config_r.flexB && pack_config_r.blockTap >= 4'h8
        |=> route_r.blockTap == $past(pack_config_r.blockTap)
    ) else $error("Block tap not taken from the register.");

    // Unsupported top cells, 0xF included, keep the supply switch open.
    cell_off_a : assert property ( // R12
        pack_config_r.cellA < 4'h8 || pack_config_r.cellA == 4'hf
        |=> !route_r.supplyOn && route_r.supplySel == 4'hf
    ) else $error("Supply switch closed on an unsupported cell.");

    // Agreed supported cells with flex on close switch input 8 to 14.
    supply_map_a : assert property ( // R11
        pack_config_r.flexA && pack_config_r.flexB && pack_config_r.cellA == pack_config_r.cellB &&
        pack_config_r.cellA >= 4'h8 && pack_config_r.cellA <= 4'he
        |=> route_r.supplyOn && route_r.supplySel == $past(pack_config_r.cellA)
    ) else $error("Supply switch not mapped to the top cell.");

    // Masking follows the top cell even with flex disabled.
    mask_always_a : assert property ( // R13
        pack_config_r.cellA == pack_config_r.cellB && pack_config_r.cellA != 4'hf
        |=> route_r.balMaskOn && route_r.balMaskTop == $past(pack_config_r.cellA)
    ) else $error("Balance-switch masking ignored the top cell.");

    // The settle wait lasts exactly the configured delay.
    scan_delay_len_a : assert property ( // R3
        $fell(scanBusy_r) |-> topSampleGo_r && waitCnt_r == SCAN_DELAY_CYC
    ) else $error("Settling delay has the wrong length.");

    // Without a due delay the sample is granted next cycle.
    scan_no_delay_a : assert property ( // R4
        scanState_r == pcae_pkg::SCAN_IDLE && topSampleReq && !delayApplies
        |=> topSampleGo_r && !scanBusy_r
    ) else $error("Sample delayed without cause.");

    // A write to the pack word reaches routing two edges later.
    write_follow_a : assert property ( // R19
        regWr && hitPack && regWdata[3:0] == regWdata[7:4] && regWdata[3:0] == 4'hf
        |=> ##1 !route_r.balMaskOn && !route_r.supplyOn
    ) else $error("Routing did not follow the write.");

    // Main scenarios worth seeing in simulation.
    cover_flex_split : cover property (pack_config_r.flexA != pack_config_r.flexB);
    cover_scan_wait : cover property ($fell(scanBusy_r));
    cover_pin_rise : cover property ($rose(alertPin_r) && !linkByteAlert_r);
    cover_supply_on : cover property ($rose(route_r.supplyOn));

endmodule : pcae_regs
`default_nettype wire

// ### testbench/tb_pcae_regs.sv
/*
 * Self-checking testbench for the pack configuration and alert enable bank.
 * Assumes the bank's package and header are compiled first; the bench drives
 * every port itself and shortens the settling delay to eight cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcae_defs.svh"

module tb_pcae_regs;
    localparam int D = 8;                  // Shortened settling delay in cycles.
    logic                  clk;            // Bench clock, 4 ns period.
    logic                  rstn;           // Synchronous reset, active low.
    logic [7:0]            regAddr;        // Register address.
    logic [15:0]           regWdata;       // Register write data.
    logic                  regWr;          // Write strobe.
    logic                  regRd;          // Read strobe.
    logic [15:0]           regRdata_r;     // Read data, one cycle after the strobe.
    logic [15:0]           summaryStatus;  // Raw summary status.
    logic                  topSampleReq;   // Sequencer sample request.
    logic                  altMuxSelEff;   // Effective alternate-mux select.
    logic                  topSampleGo_r;  // Sample permission pulse.
    logic                  scanBusy_r;     // Settling delay in progress.
    pcae_pkg::pcae_route_s route_r;        // Decoded routing.
    logic                  alertPin_r;     // Alert pin request.
    logic                  linkByteAlert_r; // Link status byte request.
    logic                  packetAlert_r;  // Alert packet request.
    int                    num_errors;     // Mismatches seen.
    int                    comparisons;    // Comparisons made.

    pcae_regs #(.SCAN_DELAY_CYC(D), .ADDR_W(8)) i_dut (
        .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
        .summaryStatus(summaryStatus), .topSampleReq(topSampleReq),
        .altMuxSelEff(altMuxSelEff), .topSampleGo_r(topSampleGo_r),
        .scanBusy_r(scanBusy_r), .route_r(route_r), .alertPin_r(alertPin_r),
        .linkByteAlert_r(linkByteAlert_r), .packetAlert_r(packetAlert_r));

    // The clock toggles every half period.
    always #2 clk = ~clk;

    // One comparison; an unknown never counts as a match.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // One-cycle write; signals change only just after a rising edge.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    // One-cycle read; the data stand only in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(nm, e, regRdata_r);
    endtask : rd

    // Expected routing, worked out from the field rules independently.
    function automatic pcae_pkg::pcae_route_s exp_route(input logic [15:0] c);
        pcae_pkg::pcae_route_s r;
        logic agree;
        agree = (c[7:4] == c[3:0]);
        r.flexEff = c[15] | c[14];
        r.cellSupported = agree && c[3:0] >= 4'h8 && c[3:0] <= 4'he;
        r.supplyOn = r.cellSupported && c[15] && c[14];
        r.supplySel = r.supplyOn ? c[3:0] : 4'hf;
        r.blockTap = (r.flexEff && c[11]) ? c[11:8] : 4'hf;
        r.balMaskOn = agree && c[3:0] != 4'hf;
        r.balMaskTop = r.balMaskOn ? c[3:0] : 4'hf;
        return r;
    endfunction : exp_route

    // Reset values of both registers, the decode and the alert outputs.
    task automatic t_reset();
        rd(8'h18, 16'hefff, "pack_config reset");
        rd(8'h19, 16'h3fbf, "alert_irq_enable reset");
        chk("route reset", exp_route(16'hefff), route_r);
        chk("alerts reset", 16'h0, {alertPin_r, linkByteAlert_r, packetAlert_r});
        $display("Test reset done");
    endtask : t_reset

    // Reserved bits, read-only places and an unmapped address.
    task automatic t_access();
        wr(8'h18, 16'hffff);
        rd(8'h18, 16'hefff, "pack_config reserved");
        wr(8'h19, 16'hffff);
        rd(8'h19, 16'hbfbf, "alert enable reserved");
        wr(8'h1a, 16'h1234);
        rd(8'h1a, 16'h0000, "status read only");
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000, "unmapped read");
        $display("Test access done");
    endtask : t_access

    // Every top-cell value, then disagreements and a disabled pack.
    task automatic t_route();
        logic [15:0] c;
        logic [15:0] extra [6];
        extra = '{16'h4c99, 16'h8c99, 16'h0c99, 16'hc89a, 16'hc533, 16'hcdff};
        for (int i = 0; i < 22; i++) begin
            c = (i < 16) ? {8'hca, i[3:0], i[3:0]} : extra[i-16];
            wr(8'h18, c);
            @(posedge clk);
            #1 chk("route", exp_route(c), route_r);
            rd(8'h1b, exp_route(c), "route readback");
        end
        $display("Test route done");
    endtask : t_route

    // Each alert on its own, then the scan alert masked by its enable.
    task automatic t_alerts();
        wr(8'h19, 16'hbfbf);
        for (int i = 0; i < 16; i++) begin
            if (i != 14 && i != 6) begin
                @(posedge clk);
                summaryStatus <= 16'h1 << i;
                @(posedge clk);
                #1 chk("pin", 16'h1, alertPin_r);
                chk("packet", (i != 15), packetAlert_r);
                chk("link", (i != 15 && i != 5), linkByteAlert_r);
            end
        end
        wr(8'h19, 16'h7fff);
        @(posedge clk);
        summaryStatus <= 16'h8000;
        @(posedge clk);
        #1 chk("masked pin", 16'h0, alertPin_r);
        rd(8'h1a, 16'h8000, "status unmasked");
        @(posedge clk);
        summaryStatus <= 16'h0;
        $display("Test alerts done");
    endtask : t_alerts

    // Counts the edges from a sample request to its permission pulse.
    task automatic scan(input logic [15:0] c, input logic alt, input int n, input string nm);
        int k;
        wr(8'h18, c);
        @(posedge clk);
        altMuxSelEff <= alt;
        @(posedge clk);
        topSampleReq <= 1'b1;
        @(posedge clk);
        topSampleReq <= 1'b0;
        k = 1;
        #1;
        while (topSampleGo_r !== 1'b1 && k < 40) begin
            if (k == 2) chk("busy", 16'h1, scanBusy_r);
            if (k == 3) topSampleReq <= 1'b1; // A request while waiting is dropped.
            @(posedge clk);
            topSampleReq <= 1'b0;
            k++;
            #1;
        end
        chk(nm, n[15:0], k[15:0]);
        @(posedge clk);
        #1 chk("go single", 16'h0, {topSampleGo_r, scanBusy_r});
    endtask : scan

    // The delay applies only with option, pack, valid cell and alternate mux.
    task automatic t_scan();
        scan(16'he099, 1'b1, D + 1, "delay due");
        scan(16'he099, 1'b0, 1, "no altmux");
        scan(16'hc099, 1'b1, 1, "option clear");
        scan(16'he09a, 1'b1, 1, "cell disagree");
        scan(16'h6077, 1'b1, 1, "cell unsupported");
        $display("Test scan done");
    endtask : t_scan

    // Main sequence: reset for twelve cycles, then the scenarios in turn.
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        regAddr = 8'h0;
        regWdata = 16'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        summaryStatus = 16'h0;
        topSampleReq = 1'b0;
        altMuxSelEff = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_access();
        t_route();
        t_alerts();
        t_scan();
        tally_and_finish();
    end

    // Watchdog: the scenarios take well under two thousand cycles.
    initial begin
        #(4 * 20000);
        num_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        tally_and_finish();
    end
endmodule : tb_pcae_regs
`default_nettype wire
